// >>> hdl/mcr_mission_ctrl.sv
// Mission setup registers: control, sample interval, start delay, status
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01: control byte readable/writable; first write while running only ends mission
// R02: later control writes store normally
// R03: control bit 5 always reads zero, cannot be set
// R04: oscillator disable bit stops the clock oscillator when one
// R05: armed clear memory works only as the very next access
// R06: clear arm bit drops on the next executed memory command
// R07: mission enable is active low; gates start by interval write
// R08: wraparound bit set lets a full log overwrite oldest samples
// R09: wraparound clear stops storing when full; mission continues
// R10: low qualifier answers search when low flag set
// R11: high qualifier answers search when high flag set
// R12: clock qualifier answers search when clock alarm flag set
// R13: start delay is 16-bit, low byte at lower address
// R14: first sample waits start delay minutes, then one sample interval, before sampling
// R15: host clears wraparound when chaining devices by start delay
// R16: status writes end a mission only when they write zero to the running flag
// R17: sample interval holds an 8-bit minute count
// R18: nonzero interval write starts mission if cleared and enabled
// R19: any write in clock-to-delay span ends a running mission
// R20: running flag cleared by writing zero, never set by write
// R21: countdowns advance only on minute ticks
// R22: later samples spaced by the interval on minute boundaries
module mcr_mission_ctrl
  import mcr_pkg::*;
(
  input  wire logic       CLOCK,          // 40 MHz system clock
  input  wire logic       RST_N,          // Async reset, active low
  input  wire logic [9:0] REG_ADDR,       // Register address
  input  wire logic [7:0] REG_WDATA,      // Write data
  input  wire logic       REG_WR,         // Committed write pulse
  input  wire logic       REG_RD,         // Read strobe
  output logic      [7:0] REG_RDATA,      // Read data, next cycle
  input  wire logic       ACCESS_START,   // New device access pulse
  input  wire logic       CMD_EXEC,       // Memory command executes
  input  wire logic       CMD_IS_CLEAR,   // That command is clear memory
  input  wire logic       MINUTE_TICK,    // Clock minute boundary pulse
  input  wire logic       CLOCK_ALARM,    // Clock alarm event pulse
  input  wire logic       CORE_IDLE,      // Conversion core not busy
  input  wire logic       SAMPLE_BUSY,    // Mission conversion in progress
  input  wire logic       TEMP_VALID,     // Mission reading ready pulse
  input  wire logic [7:0] TEMP_CODE,      // Mission reading
  input  wire logic [7:0] LOW_THRESHOLD,  // Low alarm threshold
  input  wire logic [7:0] HIGH_THRESHOLD, // High alarm threshold
  input  wire logic       LOG_FULL,       // Datalog memory full
  output logic            OSC_DISABLE,    // Stop clock oscillator
  output logic            MEM_CLEAR,      // Clear memories pulse
  output logic            SAMPLE_REQ,     // Take a mission sample pulse
  output logic            DELAY_WAIT,     // Start delay running
  output logic            LOG_STORE_EN,   // Store sample into log
  output logic            LOG_WRAP,       // Wrap log pointer when full
  output logic            MISSION_RUN,    // Mission running
  output logic            SEARCH_HIT      // Answer conditional search
);

  // ==========================================================
  // State
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [7:0]  interval_r, interval_nxt;
  logic [15:0] delay_r, delay_nxt;
  logic        running_r, running_nxt;
  logic        cleared_r, cleared_nxt;
  logic        low_flag_r, low_flag_nxt;
  logic        high_flag_r, high_flag_nxt;
  logic        clk_flag_r, clk_flag_nxt;
  logic [1:0]  acc_cnt_r, acc_cnt_nxt;
  logic        clear_pulse_r;
  logic [7:0]  rdata_r;

  mcr_timer_if tif ();

  // ==========================================================
  // Write decode
  wire in_guard   = (REG_ADDR >= ADDR_GUARD_LOW) && (REG_ADDR <= ADDR_GUARD_HIGH);
  // R19 guarded write ends mission
  wire wr_end     = REG_WR && running_r && in_guard;
  // R01 ending write stores nothing
  wire wr_store   = REG_WR && !(running_r && in_guard);
  wire wr_ctrl    = wr_store && (REG_ADDR == ADDR_CONTROL);
  wire wr_intv    = wr_store && (REG_ADDR == ADDR_SAMPLE_INTERVAL);
  wire wr_dly_lo  = wr_store && (REG_ADDR == ADDR_DELAY_LOW);
  wire wr_dly_hi  = wr_store && (REG_ADDR == ADDR_DELAY_HIGH);
  // R16 status is outside the guard span
  wire wr_stat    = REG_WR && (REG_ADDR == ADDR_STATUS);

  // R07 R18 start on nonzero interval
  wire start_go   = wr_intv && (REG_WDATA != BYTE_ZERO) && cleared_r
                    && !ctrl_r[CTL_MISSION_EN_N];
  // R05 only the access right after arming
  wire clear_go   = CMD_EXEC && CMD_IS_CLEAR && ctrl_r[CTL_CLEAR_ARM]
                    && (acc_cnt_r == ACC_NEXT);
  // R20 zero written to running flag
  wire stat_stop  = wr_stat && !REG_WDATA[ST_RUNNING];
  wire stop_go    = running_r && (wr_end || stat_stop);

  wire set_low    = running_r && TEMP_VALID && (TEMP_CODE <= LOW_THRESHOLD);
  wire set_high   = running_r && TEMP_VALID && (TEMP_CODE >= HIGH_THRESHOLD);

  // ==========================================================
  // Next values
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      // R02 R03 normal store, bit 5 masked
      ctrl_nxt = REG_WDATA & CTL_WRITE_MASK;
    end else if (CMD_EXEC) begin
      // R06 any memory command disarms
      ctrl_nxt[CTL_CLEAR_ARM] = 1'b0;
    end
  end

  // R13 low byte at lower address
  always_comb begin
    delay_nxt    = delay_r;
    interval_nxt = interval_r;
    if (clear_go) begin
      delay_nxt    = WORD_ZERO;
      interval_nxt = BYTE_ZERO;
    end else begin
      // R17 plain minute count
      if (wr_intv) interval_nxt = REG_WDATA;
      if (wr_dly_lo) delay_nxt[7:0] = REG_WDATA;
      if (wr_dly_hi) delay_nxt[15:8] = REG_WDATA;
    end
  end

  // Start and stop cannot meet: start needs an idle mission
  assign running_nxt = start_go ? 1'b1 : (stop_go ? 1'b0 : running_r);
  assign cleared_nxt = clear_go ? 1'b1 : (start_go ? 1'b0 : cleared_r);

  // Status flags: a set in the clearing cycle wins
  assign low_flag_nxt  = set_low
                         || (low_flag_r && !(wr_stat && !REG_WDATA[ST_LOW_FLAG]));
  assign high_flag_nxt = set_high
                         || (high_flag_r && !(wr_stat && !REG_WDATA[ST_HIGH_FLAG]));
  assign clk_flag_nxt  = CLOCK_ALARM
                         || (clk_flag_r && !(wr_stat && !REG_WDATA[ST_CLOCK_FLAG]));

  // Counts accesses since the arm bit was written
  always_comb begin
    acc_cnt_nxt = acc_cnt_r;
    if (wr_ctrl && REG_WDATA[CTL_CLEAR_ARM]) begin
      acc_cnt_nxt = ACC_ARMED;
    end else if (ACCESS_START && (acc_cnt_r != ACC_STALE)) begin
      acc_cnt_nxt = acc_cnt_r + ACC_NEXT;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r      <= CTL_RESET;
      interval_r  <= BYTE_ZERO;
      delay_r     <= WORD_ZERO;
      running_r   <= 1'b0;
      cleared_r   <= 1'b0;
      low_flag_r  <= 1'b0;
      high_flag_r <= 1'b0;
      clk_flag_r  <= 1'b0;
      acc_cnt_r   <= ACC_STALE;
    end else begin
      ctrl_r      <= ctrl_nxt;
      interval_r  <= interval_nxt;
      delay_r     <= delay_nxt;
      running_r   <= running_nxt;
      cleared_r   <= cleared_nxt;
      low_flag_r  <= low_flag_nxt;
      high_flag_r <= high_flag_nxt;
      clk_flag_r  <= clk_flag_nxt;
      acc_cnt_r   <= acc_cnt_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      clear_pulse_r <= 1'b0;
    end else begin
      clear_pulse_r <= clear_go;
    end
  end

  // ==========================================================
  // Read path; unmapped addresses read zero
  wire [7:0] status_byte = {CORE_IDLE, cleared_r, running_r, SAMPLE_BUSY, 1'b0,
                            low_flag_r, high_flag_r, clk_flag_r};
  wire [7:0] rd_mux = (REG_ADDR == ADDR_CONTROL)         ? ctrl_r :
                      (REG_ADDR == ADDR_SAMPLE_INTERVAL) ? interval_r :
                      (REG_ADDR == ADDR_DELAY_LOW)       ? delay_r[7:0] :
                      (REG_ADDR == ADDR_DELAY_HIGH)      ? delay_r[15:8] :
                      (REG_ADDR == ADDR_STATUS)          ? status_byte : BYTE_ZERO;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= BYTE_ZERO;
    end else if (REG_RD) begin
      rdata_r <= rd_mux;
    end
  end

  // ==========================================================
  // Mission timer
  assign tif.start    = start_go;
  assign tif.stop     = stop_go;
  // R21 no ticks with oscillator stopped
  assign tif.tick     = MINUTE_TICK && !ctrl_r[CTL_OSC_DISABLE];
  assign tif.delay    = delay_r;
  // Interval is taken from the write itself so the first count is right
  assign tif.interval = start_go ? REG_WDATA : interval_r;

  mcr_mission_timer u_timer (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .tif   (tif.tmr)
  );

  // ==========================================================
  // Outputs
  assign REG_RDATA    = rdata_r;
  // R04 oscillator control
  assign OSC_DISABLE  = ctrl_r[CTL_OSC_DISABLE];
  assign MEM_CLEAR    = clear_pulse_r;
  assign SAMPLE_REQ   = tif.sample && running_r;
  assign DELAY_WAIT   = tif.waiting;
  // R08 R09 wrap or hold when log is full
  assign LOG_STORE_EN = running_r && (ctrl_r[CTL_WRAP] || !LOG_FULL);
  assign LOG_WRAP     = ctrl_r[CTL_WRAP];
  assign MISSION_RUN  = running_r;
  // R10 R11 R12 search qualifiers
  assign SEARCH_HIT   = (ctrl_r[CTL_LOW_QUAL] && low_flag_r)
                        || (ctrl_r[CTL_HIGH_QUAL] && high_flag_r)
                        || (ctrl_r[CTL_CLOCK_QUAL] && clk_flag_r);

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_end_no_store: assert property (REG_WR && running_r && (REG_ADDR == ADDR_CONTROL) // R01
    |=> !running_r && $stable(ctrl_r))
    else $error("ending write changed control byte");
  a_ctrl_store: assert property (REG_WR && !running_r && (REG_ADDR == ADDR_CONTROL) // R02
    |=> ctrl_r == ($past(REG_WDATA) & CTL_WRITE_MASK))
    else $error("control write not stored");
  a_bit5_zero: assert property (REG_RD && (REG_ADDR == ADDR_CONTROL) // R03
    |=> !REG_RDATA[5])
    else $error("control bit 5 read as one");
  a_osc_gate: assert property (OSC_DISABLE && MINUTE_TICK |-> !tif.tick) // R04
    else $error("tick passed with oscillator stopped");
  a_clear_late: assert property (CMD_EXEC && (acc_cnt_r != ACC_NEXT) |=> !MEM_CLEAR) // R05
    else $error("clear memory outside the next access");
  a_arm_drop: assert property (CMD_EXEC && !(REG_WR && (REG_ADDR == ADDR_CONTROL)) // R06
    |=> !ctrl_r[CTL_CLEAR_ARM])
    else $error("arm bit survived a memory command");
  a_start_gate: assert property (!running_r && $rose(running_r) == 1'b0 // R07
    && REG_WR && (REG_ADDR == ADDR_SAMPLE_INTERVAL) && ctrl_r[CTL_MISSION_EN_N]
    |=> !running_r)
    else $error("mission started while disabled");
  a_full_hold: assert property (LOG_FULL && !LOG_WRAP |-> !LOG_STORE_EN) // R09
    else $error("stored into full log without wrap");
  a_delay_bytes: assert property (REG_WR && !running_r && (REG_ADDR == ADDR_DELAY_HIGH) // R13
    |=> delay_r[15:8] == $past(REG_WDATA) && $stable(delay_r[7:0]))
    else $error("start delay high byte wrong");
  a_stat_keep: assert property (running_r && wr_stat && REG_WDATA[ST_RUNNING] // R16
    |=> running_r)
    else $error("status write ended mission");
  a_start_ok: assert property (start_go |=> running_r && !cleared_r) // R18
    else $error("mission did not start");
  a_run_no_set: assert property (!running_r && !start_go |=> !running_r) // R20
    else $error("running flag set without start");
  a_flag_set_wins: assert property (set_low |=> low_flag_r) // R10
    else $error("low flag lost");
  a_clear_zero: assert property (clear_go // R05
    |=> MEM_CLEAR && cleared_r && (delay_r == WORD_ZERO) && (interval_r == BYTE_ZERO))
    else $error("clear memory left values");
  a_guard_end: assert property (wr_end && !clear_go // R19
    |=> !running_r && $stable(delay_r) && $stable(interval_r))
    else $error("guarded write did not just end the mission");
  a_wrap_store: assert property (running_r && LOG_WRAP // R08
    |-> LOG_STORE_EN)
    else $error("wrapping log refused a sample");
  a_stat_stop: assert property (wr_stat && running_r && !REG_WDATA[ST_RUNNING] // R20
    |=> !running_r)
    else $error("status write of zero kept the mission");
  a_high_set: assert property (set_high // R11
    |=> high_flag_r && (SEARCH_HIT || !ctrl_r[CTL_HIGH_QUAL]))
    else $error("high flag lost");
  a_clock_flag: assert property (CLOCK_ALARM // R12
    |=> clk_flag_r)
    else $error("clock alarm flag lost");

  c_start: cover property (start_go ##[1:50] SAMPLE_REQ);
  c_end_write: cover property (wr_end);
  c_clear: cover property (clear_go);
  c_search: cover property (SEARCH_HIT && running_r);

endmodule
`default_nettype wire

// >>> hdl/mcr_pkg.sv
// Constants for the mission control register group
package mcr_pkg;

  // ==========================================================
  // Register addresses (10-bit device memory addresses)
  localparam logic [9:0] ADDR_SAMPLE_INTERVAL = 10'h20D;
  localparam logic [9:0] ADDR_CONTROL         = 10'h20E;
  localparam logic [9:0] ADDR_DELAY_LOW       = 10'h212;
  localparam logic [9:0] ADDR_DELAY_HIGH      = 10'h213;
  localparam logic [9:0] ADDR_STATUS          = 10'h214;
  // Writes inside this span end a running mission
  localparam logic [9:0] ADDR_GUARD_LOW       = 10'h200;
  localparam logic [9:0] ADDR_GUARD_HIGH      = 10'h213;

  // ==========================================================
  // Control byte fields
  localparam int CTL_OSC_DISABLE  = 7;
  localparam int CTL_CLEAR_ARM    = 6;
  localparam int CTL_MISSION_EN_N = 4;
  localparam int CTL_WRAP         = 3;
  localparam int CTL_LOW_QUAL     = 2;
  localparam int CTL_HIGH_QUAL    = 1;
  localparam int CTL_CLOCK_QUAL   = 0;
  // Bit 5 has no storage
  localparam logic [7:0] CTL_WRITE_MASK = 8'hDF;
  localparam logic [7:0] CTL_RESET      = 8'h00;

  // ==========================================================
  // Status byte fields
  localparam int ST_CORE_IDLE  = 7;
  localparam int ST_MEM_CLEAR  = 6;
  localparam int ST_RUNNING    = 5;
  localparam int ST_SAMPLING   = 4;
  localparam int ST_LOW_FLAG   = 2;
  localparam int ST_HIGH_FLAG  = 1;
  localparam int ST_CLOCK_FLAG = 0;

  // ==========================================================
  // Misc values
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [15:0] WORD_ONE      = 16'h0001;
  localparam logic [7:0]  BYTE_ONE      = 8'h01;
  // Access count: 1 means the access right after the arming one
  localparam logic [1:0]  ACC_ARMED     = 2'h0;
  localparam logic [1:0]  ACC_NEXT      = 2'h1;
  localparam logic [1:0]  ACC_STALE     = 2'h2;

  typedef enum logic [1:0] {
    MCR_IDLE,
    MCR_DELAY,
    MCR_INTERVAL
  } mcr_phase_t;

endpackage

// >>> hdl/mcr_timer_if.sv
// Link between the register group and its mission timer
`timescale 1ns/1ps
`default_nettype none
interface mcr_timer_if;
  logic        start;
  logic        stop;
  logic        tick;
  logic [15:0] delay;
  logic [7:0]  interval;
  logic        sample;
  logic        waiting;
  modport ctrl (output start, output stop, output tick, output delay, output interval,
                input sample, input waiting);
  modport tmr  (input start, input stop, input tick, input delay, input interval,
                output sample, output waiting);
endinterface
`default_nettype wire

// >>> hdl/mcr_mission_timer.sv
// Start delay and sample interval countdown for a mission
`timescale 1ns/1ps
`default_nettype none
module mcr_mission_timer
  import mcr_pkg::*;
(
  input  wire logic     clk,    // System clock
  input  wire logic     rst_n,  // Async reset, active low
  mcr_timer_if.tmr      tif     // Control side
);

  mcr_phase_t  phase_r, phase_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        sample_r, sample_nxt;

  // ==========================================================
  // Countdown
  // R14 delay then interval
  always_comb begin
    phase_nxt  = phase_r;
    cnt_nxt    = cnt_r;
    sample_nxt = 1'b0;
    if (tif.stop) begin
      phase_nxt = MCR_IDLE;
    end else if (tif.start) begin
      phase_nxt = (tif.delay == WORD_ZERO) ? MCR_INTERVAL : MCR_DELAY;
      cnt_nxt   = (tif.delay == WORD_ZERO) ? {BYTE_ZERO, tif.interval} : tif.delay;
    end else if (tif.tick) begin
      // R21 minute ticks only
      case (phase_r)
        MCR_DELAY: begin
          if (cnt_r <= WORD_ONE) begin
            phase_nxt = MCR_INTERVAL;
            cnt_nxt   = {BYTE_ZERO, tif.interval};
          end else begin
            cnt_nxt = cnt_r - WORD_ONE;
          end
        end
        MCR_INTERVAL: begin
          // R22 samples on minute ticks
          if (cnt_r <= WORD_ONE) begin
            sample_nxt = 1'b1;
            cnt_nxt    = {BYTE_ZERO, tif.interval};
          end else begin
            cnt_nxt = cnt_r - WORD_ONE;
          end
        end
        default: phase_nxt = MCR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r  <= MCR_IDLE;
      cnt_r    <= WORD_ZERO;
      sample_r <= 1'b0;
    end else begin
      phase_r  <= phase_nxt;
      cnt_r    <= cnt_nxt;
      sample_r <= sample_nxt;
    end
  end

  assign tif.sample  = sample_r;
  assign tif.waiting = (phase_r == MCR_DELAY);

  // ==========================================================
  // Checks
  a_no_idle_sample: assert property (@(posedge clk) disable iff (!rst_n) // R22
    (phase_r == MCR_IDLE) |=> !sample_r)
    else $error("sample pulse while idle");
  a_delay_no_sample: assert property (@(posedge clk) disable iff (!rst_n) // R14
    (phase_r == MCR_DELAY && !tif.start) |=> !sample_r)
    else $error("sample during start delay");
  a_tick_only_move: assert property (@(posedge clk) disable iff (!rst_n) // R21
    (!tif.tick && !tif.start && !tif.stop) |=> $stable(cnt_r))
    else $error("countdown moved without a minute tick");
  c_first_sample: cover property (@(posedge clk) disable iff (!rst_n)
    (phase_r == MCR_DELAY) ##1 (phase_r == MCR_INTERVAL) ##[1:20] sample_r);

endmodule
`default_nettype wire

// >>> sim/mcr_host_model.sv
// Host-side model: register writes, reads and memory commands
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model
  import mcr_pkg::*;
(
  input  wire logic       clk,          // System clock
  input  wire logic [7:0] rdata,        // Read data from device
  output logic      [9:0] reg_addr,     // Register address
  output logic      [7:0] reg_wdata,    // Write data
  output logic            reg_wr,       // Committed write pulse
  output logic            reg_rd,       // Read strobe
  output logic            access_start, // New access pulse
  output logic            cmd_exec,     // Command executes pulse
  output logic            cmd_is_clear  // Command is clear memory
);
  initial begin
    reg_addr     = 10'h000;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    access_start = 1'b0;
    cmd_exec     = 1'b0;
    cmd_is_clear = 1'b0;
  end

  // ==========================================================
  // Register access
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // ==========================================================
  // Commands
  // clear as next access; the extra access spoils it on purpose
  task automatic clear_mem(input logic extra_access);
    @(posedge clk);
    access_start <= 1'b1;
    @(posedge clk);
    access_start <= 1'b0;
    if (extra_access) begin
      @(posedge clk);
      access_start <= 1'b1;
      @(posedge clk);
      access_start <= 1'b0;
    end
    @(posedge clk);
    cmd_exec     <= 1'b1;
    cmd_is_clear <= 1'b1;
    @(posedge clk);
    cmd_exec     <= 1'b0;
    cmd_is_clear <= 1'b0;
  endtask

  task automatic start_chained(input logic [7:0] ctl, input logic [15:0] dly,
                               input logic [7:0] rate);
    wr(ADDR_CONTROL, ctl & 8'hF7);
    wr(ADDR_DELAY_LOW, dly[7:0]);
    wr(ADDR_DELAY_HIGH, dly[15:8]);
    wr(ADDR_SAMPLE_INTERVAL, rate);
  endtask

  task automatic end_by_status;
    wr(ADDR_STATUS, 8'hDF);
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the mission control register group
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mcr_pkg::*;
  logic       clock, rst_n, minute_tick, clock_alarm, core_idle, sample_busy;
  logic       temp_valid, log_full, wr, rd, acc, cexec, cclr;
  logic       osc_disable, mem_clear, sample_req, delay_wait, log_store_en;
  logic       log_wrap, mission_run, search_hit;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, temp_code, low_thr, high_thr, rb;
  int         err_count, samples_checked, n_samples, n_clears;

  mcr_host_model host (.clk(clock), .rdata(rdata), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .access_start(acc), .cmd_exec(cexec), .cmd_is_clear(cclr));

  mcr_mission_ctrl dut (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .ACCESS_START(acc), .CMD_EXEC(cexec),
    .CMD_IS_CLEAR(cclr), .MINUTE_TICK(minute_tick), .CLOCK_ALARM(clock_alarm),
    .CORE_IDLE(core_idle), .SAMPLE_BUSY(sample_busy), .TEMP_VALID(temp_valid),
    .TEMP_CODE(temp_code), .LOW_THRESHOLD(low_thr), .HIGH_THRESHOLD(high_thr),
    .LOG_FULL(log_full), .OSC_DISABLE(osc_disable), .MEM_CLEAR(mem_clear),
    .SAMPLE_REQ(sample_req), .DELAY_WAIT(delay_wait), .LOG_STORE_EN(log_store_en),
    .LOG_WRAP(log_wrap), .MISSION_RUN(mission_run), .SEARCH_HIT(search_hit));

  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  // Pulses last one cycle, so count them as they pass
  always @(posedge clock) begin
    if (sample_req === 1'b1) n_samples <= n_samples + 1;
    if (mem_clear === 1'b1) n_clears <= n_clears + 1;
  end

  // ==========================================================
  // Helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input string what);
    host.rd(a, rb);
    chk8(rb, exp, what);
  endtask

  task automatic settle;
    @(posedge clock);
    #1;
  endtask

  task automatic tick;
    @(posedge clock);
    minute_tick <= 1'b1;
    @(posedge clock);
    minute_tick <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic reading(input logic [7:0] code);
    @(posedge clock);
    temp_code   <= code;
    temp_valid  <= 1'b1;
    clock_alarm <= 1'b1;
    @(posedge clock);
    temp_valid  <= 1'b0;
    clock_alarm <= 1'b0;
    settle();
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(ADDR_CONTROL, CTL_RESET, "control reset");
    rd_chk(ADDR_STATUS, 8'h80, "status reset");
    chk1(mission_run, 1'b0, "run reset");
  endtask

  task automatic t_ctrl_bits;
    host.wr(ADDR_CONTROL, 8'hFF);
    rd_chk(ADDR_CONTROL, 8'hDF, "unused bit");
    chk1(osc_disable, 1'b1, "osc stop");
    chk1(log_wrap, 1'b1, "wrap on");
    host.wr(ADDR_CONTROL, 8'h00);
    settle();
    chk1(osc_disable, 1'b0, "osc run");
  endtask

  task automatic t_clear;
    host.wr(ADDR_SAMPLE_INTERVAL, 8'h07);
    host.wr(ADDR_CONTROL, 8'h50);
    host.clear_mem(1'b0);
    settle();
    chk8(8'(n_clears), 8'h01, "clear pulse");
    rd_chk(ADDR_SAMPLE_INTERVAL, BYTE_ZERO, "interval zeroed");
    rd_chk(ADDR_CONTROL, 8'h10, "arm dropped");
    rd_chk(ADDR_STATUS, 8'hC0, "cleared flag");
    host.wr(ADDR_SAMPLE_INTERVAL, 8'h05);
    settle();
    chk1(mission_run, 1'b0, "enable high");
    host.wr(ADDR_CONTROL, 8'h50);
    host.clear_mem(1'b1);
    settle();
    chk8(8'(n_clears), 8'h01, "late clear");
    rd_chk(ADDR_SAMPLE_INTERVAL, 8'h05, "interval kept");
    rd_chk(ADDR_CONTROL, 8'h10, "arm dropped late");
  endtask

  task automatic t_mission;
    host.wr(ADDR_CONTROL, 8'h40);
    host.clear_mem(1'b0);
    host.wr(ADDR_DELAY_HIGH, 8'hA5);
    rd_chk(ADDR_DELAY_HIGH, 8'hA5, "delay high");
    host.start_chained(8'h0C, 16'h0002, 8'h03);
    settle();
    chk1(mission_run, 1'b1, "started");
    chk1(delay_wait, 1'b1, "delay wait");
    rd_chk(ADDR_STATUS, 8'hA0, "status running");
    rd_chk(ADDR_DELAY_LOW, 8'h02, "delay low");
    @(posedge clock);
    log_full <= 1'b1;
    settle();
    chk1(log_store_en, 1'b0, "full no store");
    chk1(mission_run, 1'b1, "full runs");
    repeat (4) tick();
    chk8(8'(n_samples), 8'h00, "early sample");
    chk1(delay_wait, 1'b0, "delay over");
    tick();
    chk8(8'(n_samples), 8'h01, "first sample");
    repeat (3) tick();
    chk8(8'(n_samples), 8'h02, "second sample");
    reading(8'h10);
    chk1(search_hit, 1'b1, "low search");
    host.wr(ADDR_STATUS, 8'hFF);
    rd_chk(ADDR_STATUS, 8'hA5, "status write");
    chk1(mission_run, 1'b1, "status no end");
    host.wr(ADDR_CONTROL, 8'h01);
    settle();
    chk1(mission_run, 1'b0, "control ends");
    rd_chk(ADDR_CONTROL, 8'h04, "settings kept");
    host.wr(ADDR_CONTROL, 8'h01);
    rd_chk(ADDR_CONTROL, 8'h01, "later write");
    chk1(search_hit, 1'b1, "clock search");
    host.wr(ADDR_CONTROL, 8'h02);
    settle();
    chk1(search_hit, 1'b0, "no high flag");
  endtask

  task automatic t_status_end;
    host.wr(ADDR_CONTROL, 8'h48);
    host.clear_mem(1'b0);
    host.wr(ADDR_CONTROL, 8'h8A);
    host.wr(ADDR_SAMPLE_INTERVAL, 8'h01);
    settle();
    chk1(log_store_en, 1'b1, "wrap store");
    tick();
    chk8(8'(n_samples), 8'h02, "osc stopped");
    reading(8'hF0);
    chk1(search_hit, 1'b1, "high search");
    host.end_by_status();
    settle();
    chk1(mission_run, 1'b0, "status ends");
    host.wr(ADDR_STATUS, 8'hFB);
    rd_chk(ADDR_STATUS, 8'h83, "no set, low clear");
    host.wr(ADDR_CONTROL, 8'h40);
    host.clear_mem(1'b0);
    host.wr(ADDR_SAMPLE_INTERVAL, 8'hFF);
    rd_chk(ADDR_SAMPLE_INTERVAL, 8'hFF, "interval byte");
    chk1(mission_run, 1'b1, "restarted");
    host.wr(ADDR_DELAY_LOW, 8'h33);
    settle();
    chk1(mission_run, 1'b0, "guard write ends");
    rd_chk(ADDR_DELAY_LOW, BYTE_ZERO, "guard stores nothing");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    minute_tick = 1'b0;
    clock_alarm = 1'b0;
    core_idle = 1'b1;
    sample_busy = 1'b0;
    temp_valid = 1'b0;
    temp_code = 8'h00;
    low_thr = 8'h20;
    high_thr = 8'hF0;
    log_full = 1'b0;
    err_count = 0;
    samples_checked = 0;
    n_samples = 0;
    n_clears = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_ctrl_bits();
    t_clear();
    t_mission();
    t_status_end();
    wrap_up();
  end

  // A hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("[FAIL] %0t run did not finish", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
